/* File: sfsar_cfg.svh */
// register offsets, field positions and reset values of the status bank
`ifndef SFSAR_CFG_SVH
`define SFSAR_CFG_SVH

`define SFSAR_OFS_OTSD 5'h07
`define SFSAR_OFS_WARN 5'h08
`define SFSAR_OFS_REV 5'h09
`define SFSAR_OFS_I1_HI 5'h0b
`define SFSAR_OFS_I1_LO 5'h0c
`define SFSAR_OFS_I2_HI 5'h0d
`define SFSAR_OFS_I2_LO 5'h0e
`define SFSAR_RST_VAL 8'h00
`define SFSAR_CH_LSB 0
`define SFSAR_CH_MSB 3
`define SFSAR_LO_MSB 1

`endif

/* File: sfsar_pkg.sv */
// types shared by the status bank
package sfsar_pkg;
    typedef logic [7:0] sfsar_byte_t;
    typedef logic [3:0] sfsar_chan_t;
    typedef logic [9:0] sfsar_result_t;
endpackage

/* File: sfsar_flag.sv */
// one bank of per-channel latched fault flags, cleared by a register read
`timescale 1ns/10ps
`include "sfsar_cfg.svh"
module sfsar_flag #(
    parameter int NCH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [NCH-1:0] i_event,
    input wire logic [NCH-1:0] i_clear_ok,
    input wire logic i_read,
    output logic [NCH-1:0] o_flags
);
    typedef struct packed {
        logic [NCH-1:0] flags;
    } sfsar_flag_st_t;

    sfsar_flag_st_t st_q;
    sfsar_flag_st_t st_d;

    // one register byte carries the whole bank, so more than 8 cannot fit
    if (NCH < 1 || NCH > 8)
    begin : g_bad_nch
        $error("flag count out of range");
    end

    // set wins over a clearing read in the same cycle
    always_comb
    begin
        st_d = st_q;
        if (i_read)
        begin
            st_d.flags = st_q.flags & ~i_clear_ok;
        end
        st_d.flags = st_d.flags | i_event;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_flags = st_q.flags;
endmodule

/* File: sfsar_regs.sv */
// fault-status and current-result register bank of a quad switch
`timescale 1ns/10ps
`include "sfsar_cfg.svh"
// What this block does
// - ch1 shutdown flag latches; read clears when cool
// - warning bits follow live temperature, no latching
// - warning bits 3..0 are ch4..ch1, upper zero
// - warning register at 8h, resets to 00h
// - reverse flag latches; a read of 9h clears it
// - reverse bits 3..0 are ch4..ch1, upper zero
// - reverse register at 9h, resets to 00h
// - ch1 current upper byte at Bh
// - ch1 current low two bits at Ch
// - ch2 current upper byte at Dh
// - shutdown register at 7h, ch4..ch1 in 3..0
// - ch2 current low two bits at Eh
module sfsar_regs
    import sfsar_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [4:0] i_rd_addr,
    input wire logic i_rd_en,
    output sfsar_pkg::sfsar_byte_t o_rd_data,
    input wire sfsar_pkg::sfsar_chan_t i_shutdown_event,
    input wire sfsar_pkg::sfsar_chan_t i_below_release,
    input wire sfsar_pkg::sfsar_chan_t i_warn_level,
    input wire sfsar_pkg::sfsar_chan_t i_reverse_event,
    input wire logic i_ch1_conv_done,
    input wire sfsar_pkg::sfsar_result_t i_ch1_conv_result,
    input wire logic i_ch2_conv_done,
    input wire sfsar_pkg::sfsar_result_t i_ch2_conv_result
);
    import sfsar_pkg::*;

    // ========================================
    // state
    typedef struct packed {
        sfsar_result_t ch1;
        sfsar_result_t ch2;
        sfsar_byte_t rd;
    } sfsar_st_t;

    sfsar_st_t st_q;
    sfsar_st_t st_d;
    sfsar_chan_t otsd_flags;
    sfsar_chan_t rev_flags;
    logic rd_otsd;
    logic rd_rev;

    function automatic sfsar_byte_t pad4(input sfsar_chan_t v);
        pad4 = {4'h0, v};
    endfunction

    assign rd_otsd = i_rd_en && (i_rd_addr == `SFSAR_OFS_OTSD);
    assign rd_rev = i_rd_en && (i_rd_addr == `SFSAR_OFS_REV);

    // ========================================
    // latched fault flags
    sfsar_flag #(
        .NCH(4)
    ) u_otsd (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_event(i_shutdown_event),
        .i_clear_ok(i_below_release),
        .i_read(rd_otsd),
        .o_flags(otsd_flags)
    );

    sfsar_flag #(
        .NCH(4)
    ) u_rev (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_event(i_reverse_event),
        .i_clear_ok(4'hf),
        .i_read(rd_rev),
        .o_flags(rev_flags)
    );

    // ========================================
    // results and read mux
    always_comb
    begin
        st_d = st_q;
        // whole 10-bit word captured at once so halves never tear
        if (i_ch1_conv_done)
        begin
            st_d.ch1 = i_ch1_conv_result;
        end
        if (i_ch2_conv_done)
        begin
            st_d.ch2 = i_ch2_conv_result;
        end
        st_d.rd = `SFSAR_RST_VAL;
        if (i_rd_en)
        begin
            unique case (i_rd_addr)
                `SFSAR_OFS_OTSD: st_d.rd = pad4(otsd_flags);
                `SFSAR_OFS_WARN: st_d.rd = pad4(i_warn_level);
                `SFSAR_OFS_REV: st_d.rd = pad4(rev_flags);
                `SFSAR_OFS_I1_HI: st_d.rd = st_q.ch1[9:2];
                `SFSAR_OFS_I1_LO: st_d.rd = {6'h00, st_q.ch1[1:0]};
                `SFSAR_OFS_I2_HI: st_d.rd = st_q.ch2[9:2];
                `SFSAR_OFS_I2_LO: st_d.rd = {6'h00, st_q.ch2[1:0]};
                default: st_d.rd = `SFSAR_RST_VAL;
            endcase
        end
        else
        begin
            st_d.rd = st_q.rd;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_rd_data = st_q.rd;

    // ========================================
    // checks
    // flags are watched one edge after the read that clears them
    rev_set_wins_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rd_rev && i_reverse_event[0] |=> rev_flags[0])
        else $error("reverse event lost on clearing read");
    otsd_set_wins_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rd_otsd && i_shutdown_event[0] |=> otsd_flags[0])
        else $error("shutdown event lost on clearing read");
    rev_clear_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rd_rev && !i_reverse_event[0] |=> !rev_flags[0])
        else $error("reverse flag not cleared by read");
    rev_all_clear_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rd_rev && i_reverse_event == 4'h0 |=> rev_flags == 4'h0)
        else $error("reverse flags not all cleared");
    rev_latch_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_reverse_event[3] |=> rev_flags[3])
        else $error("reverse event not latched");
    rev_keep_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !rd_rev |=> (rev_flags & $past(rev_flags)) == $past(rev_flags))
        else $error("reverse flag lost without read");
    otsd_hold_hot_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        otsd_flags[0] && !i_below_release[0] |=> otsd_flags[0])
        else $error("shutdown flag cleared while hot");
    otsd_clear_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rd_otsd && i_below_release[0] && !i_shutdown_event[0]
        |=> !otsd_flags[0])
        else $error("shutdown flag not cleared");
    otsd_latch_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_shutdown_event[0] |=> otsd_flags[0])
        else $error("shutdown event not latched");
    otsd_keep_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !rd_otsd |=> (otsd_flags & $past(otsd_flags)) == $past(otsd_flags))
        else $error("shutdown flag lost without read");
    otsd_read_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rd_otsd |=> o_rd_data == {4'h0, $past(otsd_flags)})
        else $error("shutdown read mismatch");
    warn_read_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_rd_en && i_rd_addr == `SFSAR_OFS_WARN
        |=> o_rd_data == {4'h0, $past(i_warn_level)})
        else $error("warning read mismatch");
    warn_upper_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_rd_en && i_rd_addr == `SFSAR_OFS_WARN
        |=> o_rd_data[7:4] == 4'h0)
        else $error("warning reserved bits set");
    warn_ch4_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_rd_en && i_rd_addr == `SFSAR_OFS_WARN
        |=> o_rd_data[3] == $past(i_warn_level[3]))
        else $error("warning ch4 bit misplaced");
    rev_read_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rd_rev |=> o_rd_data[7:4] == 4'h0)
        else $error("reverse reserved bits set");
    rev_data_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        rd_rev |=> o_rd_data == {4'h0, $past(rev_flags)})
        else $error("reverse read mismatch");
    rd_hold_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !i_rd_en |=> $stable(o_rd_data))
        else $error("read data moved without read");
    i1_high_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ch1_conv_done ##1 (i_rd_en && i_rd_addr == `SFSAR_OFS_I1_HI
        && !i_ch1_conv_done)
        |=> o_rd_data == $past(i_ch1_conv_result[9:2], 2))
        else $error("ch1 upper byte mismatch");
    i1_low_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ch1_conv_done ##1 (i_rd_en && i_rd_addr == `SFSAR_OFS_I1_LO
        && !i_ch1_conv_done)
        |=> o_rd_data == {6'h00, $past(i_ch1_conv_result[1:0], 2)})
        else $error("ch1 low bits mismatch");
    i2_high_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ch2_conv_done ##1 (i_rd_en && i_rd_addr == `SFSAR_OFS_I2_HI
        && !i_ch2_conv_done)
        |=> o_rd_data == $past(i_ch2_conv_result[9:2], 2))
        else $error("ch2 upper byte mismatch");
    i2_low_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ch2_conv_done ##1 (i_rd_en && i_rd_addr == `SFSAR_OFS_I2_LO
        && !i_ch2_conv_done)
        |=> o_rd_data == {6'h00, $past(i_ch2_conv_result[1:0], 2)})
        else $error("ch2 low bits mismatch");
    i1_pair_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ch1_conv_done |=> st_q.ch1 == $past(i_ch1_conv_result))
        else $error("ch1 result word torn");
    i2_pair_a:
        assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ch2_conv_done |=> st_q.ch2 == $past(i_ch2_conv_result))
        else $error("ch2 result word torn");
endmodule

/* File: sfsar_host.sv */
// host model issuing one-cycle register reads
`timescale 1ns/10ps
module sfsar_host (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_rd_data,
    output logic o_rd_en,
    output logic [4:0] o_rd_addr
);
    initial
    begin
        o_rd_en = 1'b0;
        o_rd_addr = 5'h00;
    end
    // data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        o_rd_en <= 1'b1;
        o_rd_addr <= a;
        @(posedge i_sys_clk);
        o_rd_en <= 1'b0;
        #1 d = i_rd_data;
    endtask
endmodule

/* File: switch_fault_status_adc_regs_tb_top.sv */
// bench for the fault-status and current-result bank
`timescale 1ns/10ps
module switch_fault_status_adc_regs_tb_top;
    import sfsar_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, rd_en, done1 = 1'b0, done2 = 1'b0;
    logic [4:0] addr;
    sfsar_byte_t rd_data;
    sfsar_chan_t shut = 4'h0, below = 4'h0, warn = 4'h0, rev = 4'h0;
    sfsar_result_t res1 = 10'h000, res2 = 10'h000;
    int num_errors = 0, comparisons = 0, cyc = 0;
    logic [4:0] offs[8] = '{5'h07, 5'h08, 5'h09, 5'h0b, 5'h0c, 5'h0d,
        5'h0e, 5'h1f};
    always #12.5 clk = ~clk;
    sfsar_regs i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_rd_addr(addr),
        .i_rd_en(rd_en), .o_rd_data(rd_data), .i_shutdown_event(shut),
        .i_below_release(below), .i_warn_level(warn),
        .i_reverse_event(rev), .i_ch1_conv_done(done1),
        .i_ch1_conv_result(res1), .i_ch2_conv_done(done2),
        .i_ch2_conv_result(res2));
    sfsar_host i_host (.i_sys_clk(clk), .i_rd_data(rd_data),
        .o_rd_en(rd_en), .o_rd_addr(addr));
    task automatic chk(input string n, input sfsar_byte_t e,
        input sfsar_byte_t g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [4:0] a, input sfsar_byte_t e);
        sfsar_byte_t d;
        i_host.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // whole run needs under a hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    // ==========
    // tests
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        foreach (offs[i]) rc(offs[i], 8'h00);
        $display("reset test done");
        warn <= 4'ha;
        rc(5'h08, 8'h0a);
        rc(5'h08, 8'h0a);
        warn <= 4'h5;
        rc(5'h08, 8'h05);
        $display("warning test done");
        rev <= 4'h9;
        @(posedge clk);
        rev <= 4'h0;
        rc(5'h09, 8'h09);
        rc(5'h09, 8'h00);
        rev <= 4'h2;
        rc(5'h09, 8'h02);
        rev <= 4'h0;
        rc(5'h09, 8'h02);
        rc(5'h09, 8'h00);
        $display("reverse test done");
        shut <= 4'h5;
        @(posedge clk);
        shut <= 4'h0;
        rc(5'h07, 8'h05);
        below <= 4'h1;
        rc(5'h07, 8'h05);
        rc(5'h07, 8'h04);
        below <= 4'hf;
        rc(5'h07, 8'h04);
        rc(5'h07, 8'h00);
        $display("shutdown test done");
        res1 <= 10'h2d7;
        res2 <= 10'h1fe;
        done1 <= 1'b1;
        done2 <= 1'b1;
        @(posedge clk);
        done1 <= 1'b0;
        done2 <= 1'b0;
        rc(5'h0b, 8'hb5);
        rc(5'h0c, 8'h03);
        rc(5'h0d, 8'h7f);
        rc(5'h0e, 8'h02);
        $display("result test done");
        report_and_stop();
    end
endmodule
